// >>> design/dtc_pkg.sv
// shared constants and types of the dual time base capture/compare unit
`default_nettype none

package dtc_pkg;

    // ****************************************************************
    // sizes and timing
    // ****************************************************************
    localparam int TIMER_W = 16;
    localparam int NCH = 12;
    localparam int NDBL = 4;
    localparam int DBL_OFS = 8;
    localparam int CLK_NS = 40;
    localparam int CLK_UNIT_NS = 20;
    localparam int RES_UNITS = 16;
    // finest count step in clocks, rounded up
    localparam int TICK_CYCLES = (RES_UNITS * CLK_UNIT_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************************************
    // register offsets (byte addresses, low eight bits decoded)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CNT_A = 8'h04;
    localparam logic [7:0] OFS_RLD_A = 8'h08;
    localparam logic [7:0] OFS_CNT_B = 8'h0C;
    localparam logic [7:0] OFS_RLD_B = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_DBL = 8'h1C;
    localparam logic [7:0] OFS_CFG0 = 8'h40;
    localparam logic [7:0] OFS_VAL0 = 8'h80;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int CTRL_RUN_A = 0;
    localparam int CTRL_RUN_B = 1;
    localparam int CFG_TSEL = 3;
    localparam int IRQ_TA = 12;
    localparam int IRQ_TB = 13;
    localparam int IRQ_W = 14;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [13:0] IRQ_RST = 14'h0000;
    localparam logic [3:0] CFG_RST = 4'h0;
    localparam logic [3:0] DBL_RST = 4'h0;

    // channel operating mode, low three bits of a channel config word
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        CAP_RISE = 3'h1,
        CAP_FALL = 3'h2,
        CAP_BOTH = 3'h3,
        CMP0 = 3'h4,
        CMP1 = 3'h5,
        CMP2 = 3'h6,
        CMP3 = 3'h7
    } dtc_mode_t;

endpackage : dtc_pkg

`default_nettype wire

// >>> design/dtc_timebase.sv
// one reloadable 16-bit time base
`default_nettype none

module dtc_timebase #(
    parameter int W = dtc_pkg::TIMER_W
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic [W-1:0] reload,
    // state
    output logic [W-1:0] count_q,
    output logic step_q,
    output logic ovf_q
);

    // software load beats counting so a written value is never skipped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= W'(dtc_pkg::TIMER_RST);
        end else if (load) begin
            count_q <= load_val;
        end else if (run && tick) begin
            if (&count_q) begin
                count_q <= reload;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // step marks the cycle in which the new count stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            step_q <= run & tick & ~load;
            ovf_q <= run & tick & ~load & (&count_q);
        end
    end

endmodule : dtc_timebase

`default_nettype wire

// >>> design/dtc_channel.sv
// one capture/compare channel with its pin logic
`default_nettype none

module dtc_channel #(
    parameter int W = dtc_pkg::TIMER_W
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // configuration
    input wire dtc_pkg::dtc_mode_t mode,
    input wire logic dbl_lower,
    input wire logic dbl_upper,
    input wire logic partner_match,
    // assigned time base
    input wire logic [W-1:0] tmr_count,
    input wire logic tmr_step,
    input wire logic tmr_ovf,
    input wire logic [W-1:0] value,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n,
    // events
    output logic cap_stb,
    output logic match,
    output logic event_stb
);

    logic sync1_q, sync2_q, prev_q, once_q, lvl_q;
    logic rise, fall, is_cmp, single, cmp_evt;

    // pin is asynchronous: two flops, then a third for edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // edge select and compare decode
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    assign cap_stb = ((mode == dtc_pkg::CAP_RISE) & rise)
        | ((mode == dtc_pkg::CAP_FALL) & fall)
        | ((mode == dtc_pkg::CAP_BOTH) & (rise | fall));
    assign is_cmp = (mode == dtc_pkg::CMP0) | (mode == dtc_pkg::CMP1)
        | (mode == dtc_pkg::CMP2) | (mode == dtc_pkg::CMP3);
    assign match = is_cmp & tmr_step & (tmr_count == value);
    // pair mode lets the pair fire freely, so the once limit is lifted
    assign single = ((mode == dtc_pkg::CMP2) | (mode == dtc_pkg::CMP3)) & ~dbl_lower & ~dbl_upper;
    assign cmp_evt = match & ~(single & once_q);
    assign event_stb = cap_stb | cmp_evt;

    // once-per-period latch, rearmed by the assigned time base overflow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            once_q <= 1'b0;
        end else if (cmp_evt && single) begin
            once_q <= 1'b1;
        end else if (tmr_ovf || !single) begin
            once_q <= 1'b0;
        end
    end

    // pin level; a match set wins over an overflow clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_q <= 1'b0;
        end else if (dbl_lower && is_cmp) begin
            lvl_q <= lvl_q ^ (match | partner_match);
        end else if (mode == dtc_pkg::CMP1) begin
            lvl_q <= lvl_q ^ match;
        end else if (mode == dtc_pkg::CMP3) begin
            if (cmp_evt) begin
                lvl_q <= 1'b1;
            end else if (tmr_ovf) begin
                lvl_q <= 1'b0;
            end
        end
    end

    // capture modes, and interrupt-only modes except on a pair's lower channel, leave the pin to the outside
    assign pin_o = lvl_q;
    assign pin_oe_n = ~(~dbl_upper & is_cmp
        & (dbl_lower | (mode == dtc_pkg::CMP1) | (mode == dtc_pkg::CMP3)));

    // ****************************************************************
    // checks
    // ****************************************************************
    rise_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == dtc_pkg::CAP_RISE && $rose(pin_i)) ##1 (mode == dtc_pkg::CAP_RISE && pin_i)
        |=> cap_stb && event_stb)
        else $error("rising edge not captured");
    fall_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == dtc_pkg::CAP_FALL && $rose(pin_i)) ##1 (mode == dtc_pkg::CAP_FALL && pin_i)
        |=> !cap_stb)
        else $error("falling mode captured a rising edge");
    once_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (single && cmp_evt) |=> once_q)
        else $error("compare event did not arm the once latch");
    pair_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dbl_lower && is_cmp && (partner_match ^ match)) |=> (pin_o != $past(pin_o)))
        else $error("pair match did not toggle pin");
    mode3_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (single && mode == dtc_pkg::CMP3 && cmp_evt) |=> pin_o && !pin_oe_n)
        else $error("mode 3 match did not set pin");

endmodule : dtc_channel

`default_nettype wire

// >>> design/dtc_unit.sv
// top of the dual time base capture/compare unit with its AHB-Lite slave
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`default_nettype none

module dtc_unit #(
    parameter int NCH = dtc_pkg::NCH,
    parameter int W = dtc_pkg::TIMER_W,
    parameter int TICK_CYCLES = dtc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // channel pins, enable low while driven
    input wire logic [NCH-1:0] chan_pin_i,
    output logic [NCH-1:0] chan_pin_o,
    output logic [NCH-1:0] chan_pin_oe_n,
    // interrupt
    output logic irq
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] base);
        chan_hit = (a[7:6] == base[7:6]) && (a[5:2] < 4'(NCH)) && (a[1:0] == 2'b00);
    endfunction : chan_hit

    function automatic logic [3:0] chan_idx(input logic [7:0] a);
        chan_idx = a[5:2];
    endfunction : chan_idx

    logic wr_pend_q, rd_pend_q, rd_wait_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q, rdata;
    logic take, wr;
    logic [1:0] ctrl_q;
    logic [W-1:0] rld_a_q, rld_b_q;
    logic [dtc_pkg::IRQ_W-1:0] status_q, mask_q, ev;
    logic [3:0] dbl_q;
    logic [3:0] cfg_q [NCH];
    logic [W-1:0] val_q [NCH];
    logic [W-1:0] cnt_sel [NCH];
    logic [NCH-1:0] cap_stb, match, chan_ev;
    logic [W-1:0] cnt_a, cnt_b;
    logic step_a, step_b, ovf_a, ovf_b;
    logic [7:0] tick_cnt_q;
    logic tick;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    // reads take one wait state so that hrdata comes from a flop and a
    // write just before it is already visible
    assign take = hsel & hready & htrans[1];
    assign wr = wr_pend_q;
    assign hreadyout = ~(rd_pend_q & ~rd_wait_q);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hreadyout) begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // read wait and data flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            rd_wait_q <= rd_pend_q & ~rd_wait_q;
            if (rd_pend_q && !rd_wait_q) begin
                hrdata_q <= rdata;
            end
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (addr_q)
            dtc_pkg::OFS_CTRL: rdata[1:0] = ctrl_q;
            dtc_pkg::OFS_CNT_A: rdata[W-1:0] = cnt_a;
            dtc_pkg::OFS_RLD_A: rdata[W-1:0] = rld_a_q;
            dtc_pkg::OFS_CNT_B: rdata[W-1:0] = cnt_b;
            dtc_pkg::OFS_RLD_B: rdata[W-1:0] = rld_b_q;
            dtc_pkg::OFS_STATUS: rdata[dtc_pkg::IRQ_W-1:0] = status_q;
            dtc_pkg::OFS_MASK: rdata[dtc_pkg::IRQ_W-1:0] = mask_q;
            dtc_pkg::OFS_DBL: rdata[3:0] = dbl_q;
            default: begin
                if (chan_hit(addr_q, dtc_pkg::OFS_CFG0)) begin
                    rdata[3:0] = cfg_q[chan_idx(addr_q)];
                end else if (chan_hit(addr_q, dtc_pkg::OFS_VAL0)) begin
                    rdata[W-1:0] = val_q[chan_idx(addr_q)];
                end
            end
        endcase
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    // run bits, reload values and pair enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= dtc_pkg::CTRL_RST;
            rld_a_q <= W'(dtc_pkg::TIMER_RST);
            rld_b_q <= W'(dtc_pkg::TIMER_RST);
            dbl_q <= dtc_pkg::DBL_RST;
        end else if (wr) begin
            case (addr_q)
                dtc_pkg::OFS_CTRL: ctrl_q <= hwdata[1:0];
                dtc_pkg::OFS_RLD_A: rld_a_q <= hwdata[W-1:0];
                dtc_pkg::OFS_RLD_B: rld_b_q <= hwdata[W-1:0];
                dtc_pkg::OFS_DBL: dbl_q <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // channel config: mode and timer select per channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_q[i] <= dtc_pkg::CFG_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr && chan_hit(addr_q, dtc_pkg::OFS_CFG0) && chan_idx(addr_q) == 4'(i)) begin
                    cfg_q[i] <= hwdata[3:0];
                end
            end
        end
    end

    // channel values: a capture wins over a software write in one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCH; i++) begin
                val_q[i] <= W'(dtc_pkg::TIMER_RST);
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cap_stb[i]) begin
                    val_q[i] <= cnt_sel[i];
                end else if (wr && chan_hit(addr_q, dtc_pkg::OFS_VAL0)
                        && chan_idx(addr_q) == 4'(i)) begin
                    val_q[i] <= hwdata[W-1:0];
                end
            end
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign ev = {ovf_b, ovf_a, chan_ev};

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= dtc_pkg::IRQ_RST;
            mask_q <= dtc_pkg::IRQ_RST;
        end else begin
            if (wr && addr_q == dtc_pkg::OFS_STATUS) begin
                status_q <= (status_q & ~hwdata[dtc_pkg::IRQ_W-1:0]) | ev;
            end else begin
                status_q <= status_q | ev;
            end
            if (wr && addr_q == dtc_pkg::OFS_MASK) begin
                mask_q <= hwdata[dtc_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // ****************************************************************
    // time bases
    // ****************************************************************
    // one shared prescaler sets the count step for both time bases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 8'h00;
        end else if (tick) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    assign tick = (tick_cnt_q == 8'(TICK_CYCLES - 1));

    dtc_timebase #(.W(W)) u_timebase_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ctrl_q[dtc_pkg::CTRL_RUN_A]),
        .tick(tick),
        .load(wr && addr_q == dtc_pkg::OFS_CNT_A),
        .load_val(hwdata[W-1:0]),
        .reload(rld_a_q),
        .count_q(cnt_a),
        .step_q(step_a),
        .ovf_q(ovf_a)
    );

    dtc_timebase #(.W(W)) u_timebase_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ctrl_q[dtc_pkg::CTRL_RUN_B]),
        .tick(tick),
        .load(wr && addr_q == dtc_pkg::OFS_CNT_B),
        .load_val(hwdata[W-1:0]),
        .reload(rld_b_q),
        .count_q(cnt_b),
        .step_q(step_b),
        .ovf_q(ovf_b)
    );

    // ****************************************************************
    // channel array
    // ****************************************************************
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        logic tsel, lower, upper, partner;
        assign tsel = cfg_q[i][dtc_pkg::CFG_TSEL];
        assign cnt_sel[i] = tsel ? cnt_b : cnt_a;
        if (i < dtc_pkg::NDBL && i + dtc_pkg::DBL_OFS < NCH) begin : g_low
            assign lower = dbl_q[i];
            assign upper = 1'b0;
            assign partner = match[i + dtc_pkg::DBL_OFS];
        end else if (i >= dtc_pkg::DBL_OFS && i < dtc_pkg::DBL_OFS + dtc_pkg::NDBL) begin : g_up
            assign lower = 1'b0;
            assign upper = dbl_q[i - dtc_pkg::DBL_OFS];
            assign partner = 1'b0;
        end else begin : g_solo
            assign lower = 1'b0;
            assign upper = 1'b0;
            assign partner = 1'b0;
        end

        dtc_channel #(.W(W)) u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .mode(dtc_pkg::dtc_mode_t'(cfg_q[i][2:0])),
            .dbl_lower(lower),
            .dbl_upper(upper),
            .partner_match(partner),
            .tmr_count(cnt_sel[i]),
            .tmr_step(tsel ? step_b : step_a),
            .tmr_ovf(tsel ? ovf_b : ovf_a),
            .value(val_q[i]),
            .pin_i(chan_pin_i[i]),
            .pin_o(chan_pin_o[i]),
            .pin_oe_n(chan_pin_oe_n[i]),
            .cap_stb(cap_stb[i]),
            .match(match[i]),
            .event_stb(chan_ev[i])
        );
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    capture_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_stb[0] |=> (val_q[0] == $past(cnt_sel[0])) && status_q[0])
        else $error("capture did not load timer value and flag");
    reload_ovf_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_a |-> (cnt_a == $past(rld_a_q)) ##1 status_q[dtc_pkg::IRQ_TA])
        else $error("overflow did not reload or flag");
    // cycles since the last step of time base A, saturating; the count step
    // is a parameter, so the spacing is checked on a counter, not a repetition
    logic [7:0] since_step_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_step_q <= 8'hFF;
        end else if (step_a) begin
            since_step_q <= 8'h00;
        end else if (since_step_q != 8'hFF) begin
            since_step_q <= since_step_q + 8'h01;
        end
    end

    step_spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
        step_a |-> (since_step_q >= 8'(TICK_CYCLES - 1)))
        else $error("time base stepped faster than the count step");
    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    clear_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && addr_q == dtc_pkg::OFS_STATUS && hwdata[0] && !ev[0]) |=> !status_q[0])
        else $error("write one did not clear status");
    event_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (chan_ev[1] && mask_q[1]) |=> status_q[1] && irq)
        else $error("compare event lost or interrupt not raised");
    reload_ovf_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_b |-> (cnt_b == $past(rld_b_q)) ##1 status_q[dtc_pkg::IRQ_TB])
        else $error("second time base overflow did not reload or flag");
    upper_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(dbl_q & ~chan_pin_oe_n[dtc_pkg::DBL_OFS +: dtc_pkg::NDBL])))
        else $error("paired upper channel drives its pin");

    capture_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) cap_stb[0]);
    overflow_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) ovf_b);
    pair_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
        |(dbl_q & match[dtc_pkg::DBL_OFS +: dtc_pkg::NDBL]));
    irq_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

endmodule : dtc_unit

`default_nettype wire

// >>> tb/dtc_pin_model.sv
// outside world on the channel pins: signal sources and loads
`default_nettype none

module dtc_pin_model (
    // levels the outside world drives on released pins
    input wire logic [11:0] ext_drv,
    // unit side of the pins
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe_n,
    output logic [11:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven pin reads back the unit's level, a released one the source level
    assign pin_i = (pin_o & ~pin_oe_n) | (ext_drv & pin_oe_n);
endmodule : dtc_pin_model

`default_nettype wire

// >>> tb/dual_timebase_capture_compare_test.sv
// self-checking bench of the capture/compare unit over its AHB-Lite port
`default_nettype none

module dual_timebase_capture_compare_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cnt_en = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, irq;
    logic [11:0] pin_i, pin_o, pin_oe_n, ext_drv = 12'h000, last_o = 12'h000;
    int bad_count = 0, samples_checked = 0, cycles = 0, tog3 = 0, rise4 = 0, fall4 = 0;
    assign hready = hreadyout;

    // ****************************************************************
    // design, pins and clock
    // ****************************************************************
    // short prescaler keeps a timer period at 32 clocks
    dtc_unit #(.TICK_CYCLES(2)) u_dtc_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_pin_i(pin_i), .chan_pin_o(pin_o), .chan_pin_oe_n(pin_oe_n), .irq(irq));
    dtc_pin_model u_dtc_pin_model (.ext_drv(ext_drv), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_i(pin_i));
    initial begin
        forever #20 hclk = ~hclk;
    end
    // pin edge counters and hang guard; a change at one edge is seen at the next
    always @(posedge hclk) begin
        last_o <= pin_o;
        if (cnt_en) begin
            tog3 <= tog3 + int'(pin_o[3] != last_o[3]);
            rise4 <= rise4 + int'(pin_o[4] & ~last_o[4]);
            fall4 <= fall4 + int'(~pin_o[4] & last_o[4]);
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // bus tasks and compare
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single transfer; waits on hready in both phases, data taken at the last edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask : rd_chk
    function automatic logic [7:0] cfg_a(input int i);
        return dtc_pkg::OFS_CFG0 + 8'(4 * i);
    endfunction : cfg_a
    function automatic logic [7:0] val_a(input int i);
        return dtc_pkg::OFS_VAL0 + 8'(4 * i);
    endfunction : val_a
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(dtc_pkg::OFS_STATUS, 32'h0);
        rd_chk(8'hFC, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset done");
        // stopped timers hold known counts; ch2 uses timer B
        wr(dtc_pkg::OFS_CNT_A, 32'h1234);
        wr(dtc_pkg::OFS_CNT_B, 32'h5678);
        wr(cfg_a(0), 32'h1);
        wr(cfg_a(1), 32'h2);
        wr(cfg_a(2), 32'hB);
        wr(dtc_pkg::OFS_MASK, 32'h1);
        ext_drv <= 12'h007;
        repeat (6) @(posedge hclk);
        rd_chk(dtc_pkg::OFS_STATUS, 32'h5);
        chk({31'h0, irq}, 32'h1);
        wr(dtc_pkg::OFS_STATUS, 32'h3FFF);
        @(posedge hclk); // the clear lands at the edge that ends the write
        chk({31'h0, irq}, 32'h0);
        ext_drv <= 12'h000;
        repeat (6) @(posedge hclk);
        rd_chk(dtc_pkg::OFS_STATUS, 32'h6);
        rd_chk(val_a(0), 32'h1234);
        rd_chk(val_a(1), 32'h1234);
        rd_chk(val_a(2), 32'h5678);
        $display("test capture done");
        // period of 16 counts from 0xFFF0 on both timers; ch3 paired with ch11
        wr(dtc_pkg::OFS_RLD_A, 32'hFFF0);
        wr(dtc_pkg::OFS_CNT_A, 32'hFFF0);
        wr(dtc_pkg::OFS_RLD_B, 32'hFFF0);
        wr(dtc_pkg::OFS_CNT_B, 32'hFFF0);
        wr(val_a(3), 32'hFFF4);
        wr(val_a(11), 32'hFFF8);
        wr(val_a(4), 32'hFFF8);
        wr(val_a(5), 32'hFFF4);
        wr(val_a(6), 32'hFFF4);
        wr(cfg_a(3), 32'h5);
        wr(cfg_a(11), 32'h4);
        wr(cfg_a(4), 32'h7);
        wr(cfg_a(5), 32'h4);
        wr(cfg_a(6), 32'h6);
        wr(dtc_pkg::OFS_DBL, 32'h8);
        wr(dtc_pkg::OFS_CTRL, 32'h3);
        repeat (40) @(posedge hclk);
        wr(dtc_pkg::OFS_STATUS, 32'h3FFF);
        cnt_en <= 1'b1;
        repeat (160) @(posedge hclk);
        cnt_en <= 1'b0;
        @(posedge hclk);
        chk(32'(tog3), 32'hA);
        chk(32'(rise4), 32'h5);
        chk(32'(fall4), 32'h5);
        chk({20'h0, pin_oe_n}, 32'hFE7);
        rd_chk(dtc_pkg::OFS_STATUS, 32'h3878);
        $display("test compare done");
        stop_test();
    end
endmodule : dual_timebase_capture_compare_test

`default_nettype wire
